// ===== design/srf_filter.v
// Per-input reading filter, curve selection, room calibration and label.
// Assumes readings come from a measurement channel on the same clock.
// Behaviour
// - Filter on: smooth readings exponentially; report the filtered value
// - Running average: one output per new reading, rate unchanged
// - Control path gets unfiltered reading; only sensorReading gets filtered one, temperatures use rawKelvin
// - Time constant follows 0.1/ln(N/(N-1)) with N filter points
// - Filter points default to eight
// - Filter points configurable from 2 to 64
// - Reading outside window from filter value restarts the filter
// - Window is percent of full scale, 1 to 10, default 10
// - Standard curves 1 to 20, user curves 21 to 59
// - Only curves matching the sensor type, or none, accepted
// - No curve: flag message, kelvin 0, Celsius -273.15
// - Sensor units always given; temperature only with a curve
// - Calibration starts only on thermocouple inputs with curve selected and compensation on
// - Calibration shows kelvin, saves entered value so reading matches
// - Clear command discards room calibration
// - Fifteen-character label, default is the input letter
`timescale 1ns/100ps
`default_nettype none
`include "srf_defs.vh"
module srf_filter
#(
   parameter [7:0] LETTER = 8'h41
)
(
   input wire clk,
   input wire rst,
   input wire [31:0] rawReading,
   input wire rawValid,
   output wire rawReady,
   input wire [31:0] rawKelvin,
   input wire [31:0] fullScale,
   input wire [1:0] sensorType,
   input wire filterEnable,
   input wire [6:0] filterPointsIn,
   input wire filterPointsWr,
   input wire [3:0] filterWindowIn,
   input wire filterWindowWr,
   input wire [5:0] input_curve_select_command,
   input wire [1:0] curveType,
   input wire curveSelWr,
   input wire roomCompEnable,
   input wire calStart,
   input wire calSave,
   input wire [31:0] calTrueKelvin,
   input wire calClear,
   input wire input_label_command,
   input wire [3:0] labelIdx,
   input wire [7:0] labelChar,
   input wire [3:0] labelRdIdx,
   output wire [7:0] labelRdChar,
   output reg [31:0] sensorReading,
   output reg [31:0] controlReading,
   output reg [31:0] kelvin_reading_query,
   output reg [31:0] celsius_reading_query,
   output reg readingValid,
   output reg tempValid,
   output reg no_curve_indication,
   output reg [6:0] filterPoints,
   output reg [3:0] filterWindow,
   output reg [5:0] curveNum,
   output reg calActive,
   output reg calValid,
   output reg [31:0] calOffset,
   output reg [31:0] calShowKelvin
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function curveOk;
      input [5:0] num;
      input [1:0] ctype;
      input [1:0] stype;
      begin
         curveOk = (num == `SRF_CRV_NONE) ||
            ((num <= `SRF_CRV_USR_LAST) && (ctype == stype));
      end
   endfunction

   function [31:0] absDiff;
      input [31:0] a;
      input [31:0] b;
      begin
         absDiff = ($signed(a) > $signed(b)) ? a - b : b - a;
      end
   endfunction

   // ----------------------------------------
   // Input FIFO
   // ----------------------------------------
   wire [31:0] fifoData;
   wire fifoValid;
   wire fifoTake;
   reg busy;

   srf_fifo
   #(
      .WIDTH(`SRF_DW),
      .DEPTH(`SRF_FIFO_DEPTH),
      .AW(`SRF_FIFO_AW)
   )
   uFifo
   (
      .clk(clk),
      .rst(rst),
      .inData(rawReading),
      .inValid(rawValid),
      .inReady(rawReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(fifoTake)
   );

   assign fifoTake = !busy;

   // ----------------------------------------
   // Configuration
   // ----------------------------------------
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         filterPoints <= `SRF_PTS_RST;
         filterWindow <= `SRF_WIN_RST;
         curveNum <= `SRF_CRV_NONE;
      end
      else
      begin
         if (filterPointsWr && filterPointsIn >= `SRF_PTS_MIN &&
            filterPointsIn <= `SRF_PTS_MAX)
         begin
            filterPoints <= filterPointsIn;
         end
         if (filterWindowWr && filterWindowIn >= `SRF_WIN_MIN &&
            filterWindowIn <= `SRF_WIN_MAX)
         begin
            filterWindow <= filterWindowIn;
         end
         if (curveSelWr &&
            curveOk(input_curve_select_command, curveType, sensorType))
         begin
            curveNum <= input_curve_select_command;
         end
      end
   end

   // ----------------------------------------
   // Filter datapath
   // ----------------------------------------
   // State keeps SRF_FRAC fraction bits for small steps
   reg signed [39:0] accum;
   reg primed;
   reg [31:0] sample;
   wire signed [39:0] sampleExt;
   wire signed [39:0] delta;
   wire signed [39:0] stepRaw;
   wire [31:0] filtValue;
   wire [31:0] windowLimit;
   wire [38:0] winProd;
   wire [38:0] winDiv;
   wire signed [39:0] accumNext;
   wire restart;

   assign sampleExt = {sample, 8'h00};
   assign delta = sampleExt - accum;
   // Divide by N: (N-1)/N decay per reading, step truncated toward zero
   assign stepRaw = delta / $signed({33'h0, filterPoints});
   assign filtValue = accum[39:8];
   assign winProd = fullScale * filterWindow;
   assign winDiv = winProd / 39'd100;
   assign windowLimit = winDiv[31:0];
   assign accumNext = accum + stepRaw;
   assign restart = !primed ||
      (absDiff(sample, filtValue) > windowLimit);

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         busy <= 1'b0;
         sample <= 32'h00000000;
         accum <= 40'h0000000000;
         primed <= 1'b0;
         sensorReading <= 32'h00000000;
         controlReading <= 32'h00000000;
         readingValid <= 1'b0;
      end
      else
      begin
         readingValid <= 1'b0;
         if (!busy && fifoValid)
         begin
            sample <= fifoData;
            busy <= 1'b1;
            controlReading <= fifoData;
         end
         else if (busy)
         begin
            busy <= 1'b0;
            readingValid <= 1'b1;
            if (!filterEnable)
            begin
               accum <= sampleExt;
               primed <= 1'b0;
               sensorReading <= sample;
            end
            else if (restart)
            begin
               accum <= sampleExt;
               primed <= 1'b1;
               sensorReading <= sample;
            end
            else
            begin
               accum <= accumNext;
               sensorReading <= accumNext[39:8];
            end
         end
      end
   end

   // ----------------------------------------
   // Temperature reporting and calibration
   // ----------------------------------------
   wire hasCurve;
   wire [31:0] kelvinCal;
   wire [31:0] kelvinCent;

   assign hasCurve = (curveNum != `SRF_CRV_NONE);
   assign kelvinCal = rawKelvin + calOffset;
   // Kelvin carried in 0.01 K units
   assign kelvinCent = kelvinCal;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         kelvin_reading_query <= `SRF_KELVIN_ZERO;
         celsius_reading_query <= `SRF_CELSIUS_NONE;
         tempValid <= 1'b0;
         no_curve_indication <= 1'b1;
         calActive <= 1'b0;
         calValid <= 1'b0;
         calOffset <= 32'h00000000;
         calShowKelvin <= 32'h00000000;
      end
      else
      begin
         no_curve_indication <= !hasCurve;
         tempValid <= hasCurve;
         if (hasCurve)
         begin
            kelvin_reading_query <= kelvinCent;
            celsius_reading_query <= kelvinCent + `SRF_CELSIUS_NONE;
         end
         else
         begin
            kelvin_reading_query <= `SRF_KELVIN_ZERO;
            celsius_reading_query <= `SRF_CELSIUS_NONE;
         end
         calShowKelvin <= kelvinCal;
         if (calClear)
         begin
            calOffset <= 32'h00000000;
            calValid <= 1'b0;
            calActive <= 1'b0;
         end
         else if (calActive && calSave)
         begin
            calOffset <= calTrueKelvin - rawKelvin;
            calValid <= 1'b1;
            calActive <= 1'b0;
         end
         else if (calStart && hasCurve && roomCompEnable &&
            sensorType == `SRF_TYPE_TC)
         begin
            calActive <= 1'b1;
         end
         else if (!hasCurve || !roomCompEnable)
         begin
            calActive <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Label
   // ----------------------------------------
   srf_name_store
   #(
      .LETTER(LETTER)
   )
   uName
   (
      .clk(clk),
      .rst(rst),
      .wrEn(input_label_command),
      .wrIdx(labelIdx),
      .wrChar(labelChar),
      .rdIdx(labelRdIdx),
      .rdChar(labelRdChar)
   );
endmodule
`default_nettype wire

// ===== design/srf_defs.vh
// Constants for the sensor reading filter and curve select block.
// Assumes inclusion by design files under design/.
`ifndef SRF_DEFS_VH
`define SRF_DEFS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define SRF_DW 32
`define SRF_PW 7
`define SRF_WW 4
`define SRF_CW 6
`define SRF_TW 2
`define SRF_NAME_LEN 15

// ----------------------------------------
// Filter settings
// ----------------------------------------
`define SRF_PTS_MIN 7'h02
`define SRF_PTS_MAX 7'h40
`define SRF_PTS_RST 7'h08
`define SRF_WIN_MIN 4'h1
`define SRF_WIN_MAX 4'hA
`define SRF_WIN_RST 4'hA
`define SRF_FRAC 8

// ----------------------------------------
// Curves and units
// ----------------------------------------
`define SRF_CRV_NONE 6'h00
`define SRF_CRV_STD_LAST 6'h14
`define SRF_CRV_USR_FIRST 6'h15
`define SRF_CRV_USR_LAST 6'h3B
`define SRF_TYPE_TC 2'h3
`define SRF_KELVIN_ZERO 32'h00000000
// -273.15 C in units of 0.01 C
`define SRF_CELSIUS_NONE 32'hFFFF954D
`define SRF_FIFO_DEPTH 16
`define SRF_FIFO_AW 4

`endif

// ===== design/srf_fifo.v
// Reading FIFO with valid and ready on both sides.
// Assumes one clock, asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module srf_fifo
#(
   parameter WIDTH = 32,
   parameter DEPTH = 16,
   parameter AW = 4
)
(
   input wire clk,
   input wire rst,
   input wire [WIDTH-1:0] inData,
   input wire inValid,
   output wire inReady,
   output wire [WIDTH-1:0] outData,
   output wire outValid,
   input wire outReady
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr;
   reg [AW-1:0] rdPtr;
   reg [AW:0] count;
   wire doWrite;
   wire doRead;

   assign inReady = (count != DEPTH[AW:0]);
   assign outValid = (count != {(AW+1){1'b0}});
   assign outData = mem[rdPtr];
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;

   always @(posedge clk)
   begin
      if (doWrite)
      begin
         mem[wrPtr] <= inData;
      end
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wrPtr <= {AW{1'b0}};
         rdPtr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end
      else
      begin
         if (doWrite)
         begin
            wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (doRead)
         begin
            rdPtr <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (doWrite && !doRead)
         begin
            count <= count + {{AW{1'b0}}, 1'b1};
         end
         else if (doRead && !doWrite)
         begin
            count <= count - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule
`default_nettype wire

// ===== design/srf_name_store.v
// Fifteen-character input label store.
// Assumes one clock, asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module srf_name_store
#(
   parameter [7:0] LETTER = 8'h41
)
(
   input wire clk,
   input wire rst,
   input wire wrEn,
   input wire [3:0] wrIdx,
   input wire [7:0] wrChar,
   input wire [3:0] rdIdx,
   output reg [7:0] rdChar
);
   reg [7:0] chars [0:14];
   integer i;

   // Default label is the input letter, rest spaces
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (i = 0; i < 15; i = i + 1)
         begin
            chars[i] <= (i == 0) ? LETTER : 8'h20;
         end
         rdChar <= 8'h00;
      end
      else
      begin
         if (wrEn && wrIdx < 4'hF)
         begin
            chars[wrIdx] <= wrChar;
         end
         rdChar <= (rdIdx < 4'hF) ? chars[rdIdx] : 8'h00;
      end
   end
endmodule
`default_nettype wire

// ===== sim/srf_filter_monitor.sv
// Checker for the reading filter block, bound to its ports.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module srf_filter_monitor (
   input wire clk,
   input wire rst,
   input wire rawValid,
   input wire rawReady,
   input wire readingValid,
   input wire [31:0] rawKelvin,
   input wire [31:0] calTrueKelvin,
   input wire [1:0] sensorType,
   input wire [6:0] filterPointsIn,
   input wire filterPointsWr,
   input wire [3:0] filterWindowIn,
   input wire filterWindowWr,
   input wire curveSelWr,
   input wire roomCompEnable,
   input wire calStart,
   input wire calSave,
   input wire calClear,
   input wire [31:0] kelvin_reading_query,
   input wire [31:0] celsius_reading_query,
   input wire tempValid,
   input wire no_curve_indication,
   input wire [6:0] filterPoints,
   input wire [3:0] filterWindow,
   input wire [5:0] curveNum,
   input wire calActive,
   input wire calValid,
   input wire [31:0] calOffset
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_take;
      rawValid && rawReady;
   endsequence
   sequence s_answer;
      ##[2:40] readingValid;
   endsequence
   a_read_answer: assert property (s_take |-> s_answer)
      else $error("accepted reading not answered");
   a_pts_take: assert property (filterPointsWr && filterPointsIn >= 7'h02
      && filterPointsIn <= 7'h40 |=> filterPoints == $past(filterPointsIn))
      else $error("filter points not taken");
   a_win_take: assert property (filterWindowWr && filterWindowIn >= 4'h1
      && filterWindowIn <= 4'hA |=> filterWindow == $past(filterWindowIn))
      else $error("filter window not taken");
   a_none_temps: assert property (curveNum == 6'h00 |=>
      no_curve_indication && !tempValid && kelvin_reading_query == 32'h0
      && celsius_reading_query == 32'hFFFF954D)
      else $error("no-curve readings wrong");
   a_curve_temp: assert property (curveNum != 6'h00 |=>
      tempValid && !no_curve_indication)
      else $error("temperature not valid with curve");
   a_curve_cause: assert property ($changed(curveNum) |->
      $past(curveSelWr) && curveNum <= 6'h3B)
      else $error("curve changed without write");
   a_cal_start: assert property (calStart && curveNum != 6'h00
      && roomCompEnable && sensorType == 2'h3 && !calClear && !curveSelWr
      |=> calActive)
      else $error("calibration did not start");
   a_cal_save: assert property (calActive && calSave && !calClear |=>
      calValid && calOffset == $past(calTrueKelvin) - $past(rawKelvin))
      else $error("calibration offset wrong");
   a_cal_clear: assert property (calClear |=> !calValid
      && calOffset == 32'h0)
      else $error("calibration not cleared");
endmodule
bind srf_filter srf_filter_monitor mon (.*);
`default_nettype wire

// ===== sim/srf_meas_chan.sv
// Measurement channel model: hands readings to the filter.
// Assumes the bench queues values through send().
`timescale 1ns/100ps
`default_nettype none
module srf_meas_chan (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic rawReady,
   output logic [31:0] rawReading,
   output logic rawValid
);
   logic [31:0] q[$];
   task automatic send(input logic [31:0] v);
      q.push_back(v);
   endtask
   // ----------------------------------------
   // Holds a reading until taken, scrambles data when idle
   // ----------------------------------------
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rawValid <= 1'h0;
         rawReading <= 32'h0;
      end
      else if (!rawValid || rawReady)
      begin
         if (q.size() != 0 && !(slow && rawValid))
         begin
            rawValid <= 1'h1;
            rawReading <= q.pop_front();
         end
         else
         begin
            rawValid <= 1'h0;
            rawReading <= ~rawReading;
         end
      end
   end
endmodule
`default_nettype wire

// ===== sim/srf_filter_tb_top.sv
// Self-checking bench for the reading filter block.
// Assumes design, channel model and checker compiled before it.
`timescale 1ns/100ps
`default_nettype none
module srf_filter_tb_top;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [31:0] rawKelvin = 32'h7148, fullScale = 32'h10000;
   logic [31:0] calTrueKelvin = 32'h0, seed = 32'hCA01;
   logic [6:0] filterPointsIn = 7'h0;
   logic [3:0] filterWindowIn = 4'h0, labelIdx = 4'h0, labelRdIdx = 4'h0;
   logic [5:0] input_curve_select_command = 6'h0;
   logic [1:0] sensorType = 2'h3, curveType = 2'h0;
   logic [7:0] labelChar = 8'h0;
   logic filterEnable = 1'h0, filterPointsWr = 1'h0, filterWindowWr = 1'h0;
   logic curveSelWr = 1'h0, roomCompEnable = 1'h0, calStart = 1'h0;
   logic calSave = 1'h0, calClear = 1'h0, input_label_command = 1'h0;
   logic slow = 1'h0, sawFull = 1'h0, fresh = 1'h1;
   wire [31:0] rawReading, sensorReading, controlReading, calOffset;
   wire [31:0] kelvin_reading_query, celsius_reading_query, calShowKelvin;
   wire rawValid, rawReady, readingValid, tempValid, no_curve_indication;
   wire calActive, calValid;
   wire [7:0] labelRdChar;
   wire [6:0] filterPoints;
   wire [3:0] filterWindow;
   wire [5:0] curveNum;
   logic [31:0] eq[$], rq[$];
   longint acc = 0;
   int n_errors = 0, total_checks = 0;
   logic [6:0] pv[6] = '{7'h01, 7'h40, 7'h41, 7'h02, 7'h00, 7'h04};
   logic [6:0] pe[6] = '{7'h08, 7'h40, 7'h40, 7'h02, 7'h02, 7'h04};
   logic [3:0] wv[5] = '{4'h0, 4'h1, 4'hB, 4'hA, 4'h5};
   logic [3:0] we[5] = '{4'hA, 4'h1, 4'h1, 4'hA, 4'h5};
   logic [5:0] cv[8] = '{6'h0C, 6'h05, 6'h3C, 6'h3B, 6'h15, 6'h01, 6'h14, 6'h00};
   logic [1:0] ty[8] = '{2'h3, 2'h1, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h0};
   logic [5:0] ce[8] = '{6'h0C, 6'h0C, 6'h0C, 6'h3B, 6'h15, 6'h01, 6'h14, 6'h00};

   srf_filter dut (.*);
   srf_meas_chan chan (.*);

   always #50 clk = ~clk;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Filter expectation: restart on first or out-of-window reading
   function automatic logic [31:0] model(input logic [31:0] x);
      longint xs, d, lim;
      xs = longint'($signed(x));
      if (!filterEnable)
      begin
         fresh = 1'h1;
         return x;
      end
      d = xs - (acc >>> 8);
      lim = longint'(fullScale) * longint'(filterWindowIn) / 100;
      if (fresh || d > lim || -d > lim)
         acc = xs <<< 8;
      else
         acc = acc + ((xs <<< 8) - acc) / longint'(filterPointsIn);
      fresh = 1'h0;
      return 32'(acc >>> 8);
   endfunction

   task automatic pulse(ref logic s);
      s = 1'h1;
      @(negedge clk);
      s = 1'h0;
      @(negedge clk);
   endtask

   task automatic send(input logic [31:0] x);
      rq.push_back(x);
      eq.push_back(model(x));
      chan.send(x);
   endtask

   task automatic drain();
      for (int i = 0; i < 200 && eq.size() != 0; i++)
         @(negedge clk);
      chk(eq.size(), 32'h0);
   endtask

   task automatic setCurve(input logic [5:0] n, input logic [1:0] t);
      input_curve_select_command = n;
      curveType = t;
      pulse(curveSelWr);
   endtask

   task automatic rdLabel(input logic [3:0] i, input logic [7:0] e);
      labelRdIdx = i;
      repeat (2) @(negedge clk);
      chk(labelRdChar, e);
   endtask

   always @(negedge clk)
   begin
      if (rawReady === 1'h0)
         sawFull = 1'h1;
      if (readingValid === 1'h1)
      begin
         chk(sensorReading, eq.pop_front());
         chk(controlReading, rq.pop_front());
      end
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      repeat (16) @(negedge clk);
      rst = 1'h0;
      @(negedge clk);
      chk(filterPoints, 7'h08);
      chk(filterWindow, 4'hA);
      chk(no_curve_indication, 1'h1);
      chk(celsius_reading_query, 32'hFFFF954D);
      chk(kelvin_reading_query, 32'h0);
      chk(tempValid, 1'h0);
      rdLabel(4'h0, 8'h41);
      rdLabel(4'h1, 8'h20);
      for (int i = 0; i < 40; i++)
         send(rnd());
      drain();
      chk(sawFull, 1'h1);
      foreach (pv[i])
      begin
         filterPointsIn = pv[i];
         pulse(filterPointsWr);
         chk(filterPoints, pe[i]);
      end
      foreach (wv[i])
      begin
         filterWindowIn = wv[i];
         pulse(filterWindowWr);
         chk(filterWindow, we[i]);
      end
      filterEnable = 1'h1;
      slow = 1'h1;
      for (int i = 0; i < 30; i++)
         send((rnd() & 32'h3FF) + (i >= 15 ? 32'h8000 : 32'h0));
      drain();
      foreach (cv[i])
      begin
         setCurve(cv[i], ty[i]);
         chk(curveNum, ce[i]);
         @(negedge clk);
         chk(tempValid, ce[i] != 6'h00);
         chk(no_curve_indication, ce[i] == 6'h00);
      end
      pulse(calStart);
      chk(calActive, 1'h0);
      setCurve(6'h0C, 2'h3);
      pulse(calStart);
      chk(calActive, 1'h0);
      roomCompEnable = 1'h1;
      pulse(calStart);
      chk(calActive, 1'h1);
      chk(calShowKelvin, rawKelvin);
      calTrueKelvin = 32'h7477;
      pulse(calSave);
      chk(calValid, 1'h1);
      repeat (3) @(negedge clk);
      chk(kelvin_reading_query, 32'h7477);
      chk(celsius_reading_query, 32'h9C4);
      pulse(calClear);
      chk(calValid, 1'h0);
      chk(calOffset, 32'h0);
      repeat (3) @(negedge clk);
      chk(kelvin_reading_query, rawKelvin);
      labelIdx = 4'h0;
      labelChar = 8'h42;
      pulse(input_label_command);
      labelIdx = 4'hE;
      labelChar = 8'h5A;
      pulse(input_label_command);
      rdLabel(4'hE, 8'h5A);
      rdLabel(4'hF, 8'h00);
      rdLabel(4'h0, 8'h42);
      complete_run();
   end

   initial
   begin
      #(100 * 5000);
      n_errors++;
      complete_run();
   end
endmodule
`default_nettype wire
